// file: csb_pkg.sv
// Constants and types shared by the clocked serial buffer control
package csb_pkg;

  //----------------------------------------------------------------
  // Register map
  //----------------------------------------------------------------
  localparam int unsigned AW         = 12;       // Address width
  localparam logic [11:0] BUF_BASE   = 12'h0f90; // First buffer byte
  localparam logic [11:0] BUF_LAST   = 12'h0f97; // Last buffer byte
  localparam logic [11:0] CTRL_ONE   = 12'h0f98; // Control one, write only
  localparam logic [11:0] CTRL_TWO   = 12'h0f99; // Control two, write side
  localparam logic [11:0] STATE_REG  = 12'h0f99; // Status, read side
  localparam logic [11:0] IRQ_STAT   = 12'h0fa0; // Sticky event bits
  localparam logic [11:0] IRQ_EN     = 12'h0fa1; // Event enables
  localparam logic [11:0] IRQ_CLR    = 12'h0fa2; // Write one to clear
  localparam logic [7:0]  CTRL_RESET = 8'h00;    // Control reset value

  //----------------------------------------------------------------
  // Field positions
  //----------------------------------------------------------------
  localparam int unsigned GO_BIT    = 7; // Start / stop
  localparam int unsigned ABORT_BIT = 6; // Abort request
  localparam int unsigned MODE_LO   = 3; // Mode field low bit
  localparam int unsigned CLK_LO    = 0; // Clock field low bit
  localparam int unsigned WAIT_LO   = 3; // Wait field low bit
  localparam int unsigned WORDS_LO  = 0; // Word count low bit
  localparam int unsigned EV_DONE   = 0; // Transfer complete event
  localparam int unsigned EV_ABORT  = 1; // Abort finished event

  //----------------------------------------------------------------
  // Codes and timing
  //----------------------------------------------------------------
  localparam logic [2:0] MODE_TX8  = 3'h0; // 8-bit transmit
  localparam logic [2:0] MODE_TX4  = 3'h2; // 4-bit transmit
  localparam logic [2:0] MODE_TRX8 = 3'h4; // 8-bit transmit/receive
  localparam logic [2:0] MODE_RX8  = 3'h5; // 8-bit receive
  localparam logic [2:0] MODE_RX4  = 3'h6; // 4-bit receive
  localparam logic [2:0] CLK_SLOW  = 3'h0; // Slowest divider code
  localparam logic [2:0] CLK_RSVD  = 3'h6; // Reserved clock code
  localparam logic [2:0] CLK_EXT   = 3'h7; // External clock pin
  localparam logic [3:0] LF_EXP    = 4'h5; // Low-frequency divide power
  localparam logic [3:0] DIV_EXP [0:7] = '{4'hd, 4'h8, 4'h7, 4'h6,
                                           4'h5, 4'h4, 4'h1, 4'h1};
  localparam logic [2:0] LAST_BIT8  = 3'h7; // Last bit of a byte
  localparam logic [2:0] LAST_BIT4  = 3'h3; // Last bit of a nibble
  localparam logic [7:0] HALF_WORD  = 8'h10; // Half periods per word

  //----------------------------------------------------------------
  // Types
  //----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_WAIT  = 2'b10
  } phase_t;

  typedef struct packed {
    logic [AW-1:0] addr;  // Register address
    logic [7:0]    wdata; // Write data
    logic          wr;    // Write strobe
    logic          rd;    // Read strobe
  } bus_req_t;

endpackage

// file: clocked_serial_buffer_control.sv
// Clocked serial buffer control: registers, shift engine, interrupt
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RQ1: Eight-byte buffer shared by transmit and receive
// RQ2: Up to eight words per operation, unattended
// RQ3: Interrupt once programmed word count completes
// RQ4: Wait after words, internal clock 8-bit receive
// RQ5: Start bit starts; clearing it stops transfer
// RQ6: Abort bit stops transfer and clears itself
// RQ7: Mode field selects five transfer modes
// RQ8: Clock field selects divider or external pin
// RQ9: Software sets abort, clears start when reconfiguring
// RQ10: Control one write-only, resets to zero
// RQ11: Only data out, data in, shift clock
// RQ12: Transmit on falling edge, receive on rising
// RQ13: LSB first; nibble modes zero upper half
// RQ14: Word count one to eight, lowest first
// RQ15: Active flag falls at end or abort
module clocked_serial_buffer_control
  import csb_pkg::*;
(
  input  wire logic     sys_clk,            // System clock
  input  wire logic     resetn,             // Synchronous reset, low
  input  wire bus_req_t bus_req,            // Register request
  output logic [7:0]    bus_rdata,          // Read data, next cycle
  input  wire logic     sdi,                // Serial data in pin
  output logic          sdo,                // Serial data out pin
  input  wire logic     sck_in,             // Shift clock pin level
  output logic          sck_out,            // Shift clock driven level
  output logic          sck_oe_n,           // Shift clock enable, low
  input  wire logic     lf_clk,             // Low-frequency clock
  input  wire logic     divider_tap_option, // Low-frequency tap select
  input  wire logic     low_speed_mode,     // Slow or sleep mode
  output logic          transfer_done_irq,  // Interrupt level
  output logic          transfer_active_flag // Transfer in process
);

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  typedef struct packed {
    logic            go;       // Start / stop bit
    logic            abort;    // Abort request bit
    logic [2:0]      mode;     // Transfer mode
    logic [2:0]      clk_sel;  // Shift clock select
    logic [1:0]      wait_sel; // Wait length
    logic [2:0]      words;    // Word count minus one
    logic [7:0][7:0] buffer;   // Data buffer area
    phase_t          phase;    // Engine phase
    logic [2:0]      word;     // Current word index
    logic [2:0]      bitn;     // Current bit index
    logic [7:0]      shreg;    // Receive shifter
    logic [11:0]     div;      // Divider counter
    logic [6:0]      wait_cnt; // Wait half periods left
    logic            sck;      // Internal shift clock level
    logic            sdo;      // Serial output level
    logic [2:0]      sck_sync; // Clock pin synchroniser
    logic [1:0]      sdi_sync; // Data pin synchroniser
    logic [2:0]      lf_sync;  // Low clock synchroniser
    logic [1:0]      irq_stat; // Sticky events
    logic [1:0]      irq_en;   // Event enables
    logic [7:0]      rdata;    // Read data register
  } state_t;

  state_t     st;        // Registered state
  state_t     next_st;   // Next state
  logic       int_clk;   // Internal clock selected
  logic       lf_sel;    // Low-frequency source in use
  logic       tick;      // Divider advance
  logic [11:0] limit;    // Half period minus one
  logic       fall_ev;   // Shift clock falling edge
  logic       rise_ev;   // Shift clock rising edge
  logic       store_ev;  // Received word stored
  logic       end_ev;    // Transfer terminates
  logic       start_ok;  // Start accepted
  logic       nib;       // Nibble mode
  logic [7:0] rx_word;   // Assembled receive value
  logic [1:0] irq_set;   // Events this cycle

  //----------------------------------------------------------------
  // Decoders
  //----------------------------------------------------------------
  // Half period count for a clock code
  function automatic logic [11:0] half_limit(input logic [2:0] code,
                                             input logic lf);
    logic [3:0] e;
    e = lf ? LF_EXP : DIV_EXP[code];
    return 12'((13'h1 << (e - 4'h1)) - 13'h1);
  endfunction

  // Wait half periods for a wait code, minus one
  function automatic logic [6:0] wait_load(input logic [1:0] w);
    logic [7:0] n;
    n = (8'h1 << w) - 8'h1;
    return 7'(n * HALF_WORD - 8'h1);
  endfunction

  // Mode codes that move data out
  function automatic logic is_tx(input logic [2:0] m);
    return (m == MODE_TX8) || (m == MODE_TX4) || (m == MODE_TRX8);
  endfunction

  // Mode codes that move data in
  function automatic logic is_rx(input logic [2:0] m);
    return (m == MODE_TRX8) || (m == MODE_RX8) || (m == MODE_RX4);
  endfunction

  //----------------------------------------------------------------
  // Next-state logic
  //----------------------------------------------------------------
  // Bus access, shift engine and events
  always_comb begin
    next_st  = st;
    irq_set  = 2'h0;
    fall_ev  = 1'b0;
    rise_ev  = 1'b0;
    store_ev = 1'b0;
    end_ev   = 1'b0;
    start_ok = 1'b0;
    // Pin synchronisers, first stage read only by second
    next_st.sck_sync = {st.sck_sync[1:0], sck_in};
    next_st.sdi_sync = {st.sdi_sync[0], sdi};
    next_st.lf_sync  = {st.lf_sync[1:0], lf_clk};
    // Clock source choice
    int_clk = (st.clk_sel != CLK_EXT) && (st.clk_sel != CLK_RSVD); // [RQ8]
    lf_sel  = (st.clk_sel == CLK_SLOW) &&
              (divider_tap_option || low_speed_mode); // [RQ8]
    tick    = lf_sel ? (st.lf_sync[1] & ~st.lf_sync[2]) : 1'b1;
    limit   = half_limit(st.clk_sel, lf_sel); // [RQ8]
    nib     = (st.mode == MODE_TX4) || (st.mode == MODE_RX4);
    rx_word = {st.sdi_sync[1], st.shreg[7:1]};

    // Register writes
    if (bus_req.wr) begin
      if (bus_req.addr >= BUF_BASE && bus_req.addr <= BUF_LAST) begin
        next_st.buffer[bus_req.addr[2:0]] = bus_req.wdata; // [RQ1]
      end else if (bus_req.addr == CTRL_ONE) begin
        next_st.go      = bus_req.wdata[GO_BIT];
        next_st.abort   = bus_req.wdata[ABORT_BIT];
        next_st.mode    = bus_req.wdata[MODE_LO +: 3]; // [RQ7]
        next_st.clk_sel = bus_req.wdata[CLK_LO +: 3];
        // Start from idle with a legal setup
        start_ok = bus_req.wdata[GO_BIT] && !bus_req.wdata[ABORT_BIT] &&
                   !st.abort && (st.phase == ST_IDLE) &&
                   (is_tx(bus_req.wdata[MODE_LO +: 3]) ||
                    is_rx(bus_req.wdata[MODE_LO +: 3])) &&
                   (bus_req.wdata[CLK_LO +: 3] != CLK_RSVD); // [RQ5] [RQ9]
      end else if (bus_req.addr == CTRL_TWO) begin
        next_st.wait_sel = bus_req.wdata[WAIT_LO +: 2];
        next_st.words    = bus_req.wdata[WORDS_LO +: 3]; // [RQ14]
      end else if (bus_req.addr == IRQ_EN) begin
        next_st.irq_en = bus_req.wdata[1:0];
      end
    end

    // Divider and external edges
    if (st.phase != ST_IDLE) begin
      if (int_clk) begin
        if (tick) begin
          if (st.div == limit) begin
            next_st.div = 12'h000;
            if (st.phase == ST_WAIT) begin
              // Clock held high between words
              if (st.wait_cnt == 7'h00) begin
                next_st.phase = ST_SHIFT; // [RQ4]
              end else begin
                next_st.wait_cnt = st.wait_cnt - 7'h01;
              end
            end else begin
              next_st.sck = ~st.sck;
              fall_ev     = st.sck;
              rise_ev     = ~st.sck;
            end
          end else begin
            next_st.div = st.div + 12'h001;
          end
        end
      end else if (st.phase == ST_SHIFT) begin
        // Edges from the second and third stages only
        fall_ev = st.sck_sync[2] & ~st.sck_sync[1];
        rise_ev = st.sck_sync[1] & ~st.sck_sync[2];
      end
    end

    // Output bit on falling edge, LSB first
    if (fall_ev && is_tx(st.mode)) begin
      next_st.sdo = st.buffer[st.word][st.bitn]; // [RQ12] [RQ13]
    end

    // Sample on rising edge
    if (rise_ev) begin
      next_st.shreg = rx_word; // [RQ12]
      if (st.bitn == (nib ? LAST_BIT4 : LAST_BIT8)) begin
        if (is_rx(st.mode)) begin
          store_ev = 1'b1;
          next_st.buffer[st.word] = nib ? {4'h0, rx_word[7:4]} : rx_word; // [RQ13]
        end
        next_st.bitn = 3'h0;
        if (st.word == st.words || !st.go) begin
          // Count reached, or stop bit cleared mid-transfer
          end_ev        = 1'b1;
          next_st.phase = ST_IDLE; // [RQ5] [RQ15]
          irq_set[EV_DONE] = (st.word == st.words); // [RQ3]
        end else begin
          next_st.word = st.word + 3'h1; // [RQ2] [RQ14]
          if (int_clk && st.wait_sel != 2'h0 && !nib && is_rx(st.mode)) begin
            next_st.phase    = ST_WAIT; // [RQ4]
            next_st.wait_cnt = wait_load(st.wait_sel);
            next_st.div      = 12'h000;
          end
        end
      end else begin
        next_st.bitn = st.bitn + 3'h1;
      end
    end

    // Start a new transfer at word zero
    if (start_ok) begin
      next_st.phase = ST_SHIFT; // [RQ5]
      next_st.word  = 3'h0;     // [RQ14]
      next_st.bitn  = 3'h0;
      next_st.div   = 12'h000;
      next_st.sck   = 1'b1;
    end

    // Abort wins over everything, then clears itself
    if (st.abort) begin
      next_st.abort = 1'b0; // [RQ6]
      next_st.phase = ST_IDLE; // [RQ15]
      next_st.sck   = 1'b1;
      next_st.bitn  = 3'h0;
      irq_set[EV_ABORT] = 1'b1;
    end

    // Sticky events, set wins over clear
    if (bus_req.wr && bus_req.addr == IRQ_CLR) begin
      next_st.irq_stat = st.irq_stat & ~bus_req.wdata[1:0];
    end
    next_st.irq_stat = next_st.irq_stat | irq_set;

    // Read data, control one reads as zero
    next_st.rdata = 8'h00;
    if (bus_req.rd) begin
      if (bus_req.addr >= BUF_BASE && bus_req.addr <= BUF_LAST) begin
        next_st.rdata = st.buffer[bus_req.addr[2:0]];
      end else if (bus_req.addr == STATE_REG) begin
        next_st.rdata = {st.phase != ST_IDLE, st.phase == ST_SHIFT, 6'h00};
      end else if (bus_req.addr == IRQ_STAT) begin
        next_st.rdata = {6'h00, st.irq_stat};
      end else if (bus_req.addr == IRQ_EN) begin
        next_st.rdata = {6'h00, st.irq_en};
      end
    end
  end

  //----------------------------------------------------------------
  // State register
  //----------------------------------------------------------------
  // Synchronous reset, all control zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st          <= '0; // [RQ10]
      st.mode     <= CTRL_RESET[MODE_LO +: 3];
      st.clk_sel  <= CTRL_RESET[CLK_LO +: 3];
      st.phase    <= ST_IDLE;
      st.sck      <= 1'b1;
      st.sdo      <= 1'b1;
      st.sck_sync <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  //----------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------
  // Three pins only toward the peripheral
  assign sdo                  = st.sdo; // [RQ11]
  assign sck_out              = st.sck;
  assign sck_oe_n             = ~int_clk;
  assign bus_rdata            = st.rdata;
  assign transfer_active_flag = (st.phase != ST_IDLE);
  assign transfer_done_irq    = |(st.irq_stat & st.irq_en);

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_abort_self_clear: assert property ( // [RQ6]
    bus_req.wr && bus_req.addr == CTRL_ONE && bus_req.wdata[ABORT_BIT]
    |=> st.abort ##1 (!st.abort && !transfer_active_flag))
    else $error("abort bit did not clear itself");

  a_start_active: assert property ( // [RQ5]
    start_ok |=> transfer_active_flag && st.word == 3'h0 && st.sck)
    else $error("start did not begin a transfer");

  a_done_event: assert property ( // [RQ3]
    irq_set[EV_DONE] |=> st.irq_stat[EV_DONE] && !transfer_active_flag)
    else $error("completion event lost");

  a_ctrl_write_only: assert property ( // [RQ10]
    bus_req.rd && bus_req.addr == CTRL_ONE |=> bus_rdata == 8'h00)
    else $error("control one readable");

  a_tx_on_fall: assert property ( // [RQ12]
    $changed(sdo) |-> $past(fall_ev))
    else $error("data out moved off the falling edge");

  a_rx_on_rise: assert property ( // [RQ12]
    $changed(st.shreg) |-> $past(rise_ev))
    else $error("data in sampled off the rising edge");

  a_wait_sck_high: assert property ( // [RQ4]
    st.phase == ST_WAIT |-> sck_out && !nib && is_rx(st.mode))
    else $error("wait outside 8-bit receive or clock low");

  a_nibble_zero: assert property ( // [RQ13]
    store_ev && nib |=> st.buffer[$past(st.word)][7:4] == 4'h0)
    else $error("nibble upper half not zero");

  a_active_fall: assert property ( // [RQ15]
    $fell(transfer_active_flag) |-> $past(end_ev || st.abort))
    else $error("active flag fell without cause");

  a_word_bound: assert property ( // [RQ14]
    rise_ev && st.word == st.words && st.bitn == LAST_BIT8 |=> !transfer_active_flag)
    else $error("transfer ran past word count");

  a_abort_event: assert property ( // [RQ6]
    st.abort |=> st.irq_stat[EV_ABORT] && !transfer_active_flag)
    else $error("abort finished event lost");

  a_stop_at_word: assert property ( // [RQ5]
    rise_ev && !st.go && st.bitn == (nib ? LAST_BIT4 : LAST_BIT8) |=> !transfer_active_flag)
    else $error("transfer ran on after stop");

endmodule

`default_nettype wire

// file: serial_peer.sv
// Behavioural clocked serial peripheral on the far side of the block
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input  wire logic sck_line, // Shift clock level on the wire
  input  wire logic sdo,      // Data from the block
  input  wire logic frame,    // Block reports a transfer in process
  output logic      sdi,      // Data to the block
  output logic      ext_sck,  // Clock driven by this peer
  output logic      ext_on    // Peer owns the clock line
);
  //----------------------------------------------------------------
  // Bit stores, first bit on the wire at index 0
  //----------------------------------------------------------------
  logic [63:0] tx_bits; // Bits to send
  logic [63:0] rx_bits; // Bits captured
  int          tx_idx;  // Next bit to send
  int          rx_idx;  // Next bit to capture

  // Idle values
  initial begin
    sdi = 1'b1;
    ext_sck = 1'b1;
    ext_on = 1'b0;
  end

  // New data on the falling edge of the line
  always @(negedge sck_line) begin
    sdi <= tx_bits[tx_idx];
    tx_idx <= tx_idx + 1;
  end

  // Capture on the rising edge of the line
  always @(posedge sck_line) begin
    rx_bits[rx_idx] <= sdo;
    rx_idx <= rx_idx + 1;
  end

  // Data no longer valid once the frame is over
  always @(negedge frame) sdi <= ~sdi;

  // Prepare a frame
  task automatic load(input logic [63:0] bits);
    tx_bits = bits;
    rx_bits = '0;
    tx_idx = 0;
    rx_idx = 0;
  endtask

  // Drive n clock pulses; the line stands still outside them
  task automatic run_clock(input int n, input int half);
    ext_on = 1'b1;
    repeat (n) begin
      #(half) ext_sck = 1'b0;
      #(half) ext_sck = 1'b1;
    end
    #(half) ext_on = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the clocked serial buffer control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import csb_pkg::*;
  //----------------------------------------------------------------
  // Signals
  //----------------------------------------------------------------
  logic       sys_clk, resetn, lf_clk, tap, slow; // Clocks and levels
  bus_req_t   bus_req;                            // Register request
  logic [7:0] bus_rdata;                          // Read data
  logic       sdi, sdo, sck_out, sck_oe_n, irq;   // Pins and interrupt
  logic       active, ext_sck, ext_on, sck_line;  // Flag and clock wire
  int         err_total, total_checks, n, k, w;   // Counters
  logic [2:0] rsvd [0:2] = '{3'h1, 3'h3, 3'h7};   // Reserved modes

  // Clock pin: block, peer, or pull-up
  assign sck_line = !sck_oe_n ? sck_out : (ext_on ? ext_sck : 1'b1);

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;
  initial lf_clk = 1'b0;
  always #50 lf_clk = ~lf_clk;

  clocked_serial_buffer_control dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .sdi(sdi), .sdo(sdo), .sck_in(sck_line), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .lf_clk(lf_clk), .divider_tap_option(tap), .low_speed_mode(slow),
    .transfer_done_irq(irq), .transfer_active_flag(active));

  serial_peer peer_u (
    .sck_line(sck_line), .sdo(sdo), .frame(active), .sdi(sdi),
    .ext_sck(ext_sck), .ext_on(ext_on));

  //----------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------
  function automatic logic [7:0] bval(input int i);
    return 8'(i * 35 + 31);
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 chk(bus_rdata, e);
  endtask

  // Configure with the engine held off, then start
  task automatic start(input logic [2:0] mode, input logic [2:0] clk);
    bus_wr(CTRL_ONE, {2'b01, mode, clk});
    repeat (2) @(posedge sys_clk);
    bus_wr(CTRL_ONE, {2'b10, mode, clk});
  endtask

  // Count cycles with the active flag up, bounded by lim
  task automatic measure(input int lim);
    n = 0;
    for (int i = 0; i < lim; i++) begin
      #1;
      if (active === 1'b1) n++;
      else if (n > 0) break;
      @(posedge sys_clk);
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog, well beyond the expected run
  initial begin
    #2_000_000;
    err_total++;
    finish_test;
  end

  //----------------------------------------------------------------
  // Test sequence
  //----------------------------------------------------------------
  initial begin
    err_total = 0;
    total_checks = 0;
    resetn = 1'b0;
    bus_req = '0;
    tap = 1'b0;
    slow = 1'b0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    #1 chk({sdo, sck_out, sck_oe_n, irq, active}, 16'h0018);
    rd_chk(CTRL_ONE, CTRL_RESET);
    rd_chk(STATE_REG, 8'h00);
    rd_chk(12'h0fb0, 8'h00);
    for (k = 0; k < 8; k++) bus_wr(BUF_BASE + 12'(k), bval(k));
    for (k = 0; k < 8; k++) rd_chk(BUF_BASE + 12'(k), bval(k));
    // Divider codes one to five, one byte out
    bus_wr(CTRL_TWO, 8'h00);
    for (k = 1; k < 6; k++) begin
      peer_u.load('0);
      start(MODE_TX8, 3'(k));
      measure(3000);
      chk(16'(n), 16'(1 << (12 - k)));
      chk(peer_u.rx_bits[7:0], bval(0));
    end
    // Eight words, interrupt masked then enabled then cleared
    bus_wr(IRQ_EN, 8'h00);
    bus_wr(CTRL_TWO, 8'h07);
    peer_u.load('0);
    start(MODE_TX8, 3'h5);
    measure(3000);
    chk(16'(n), 16'h0400);
    for (k = 0; k < 8; k++) chk(peer_u.rx_bits[8*k +: 8], bval(k));
    chk(irq, 1'b0);
    bus_wr(IRQ_EN, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1 chk(irq, 1'b1);
    bus_wr(IRQ_CLR, 8'h03);
    repeat (2) @(posedge sys_clk);
    #1 chk(irq, 1'b0);
    rd_chk(CTRL_ONE, 8'h00);
    // Nibble receive, upper half zeroed, fourth byte untouched
    for (k = 0; k < 4; k++) bus_wr(BUF_BASE + 12'(k), 8'hff);
    bus_wr(CTRL_TWO, 8'h02);
    peer_u.load(64'h0000_0000_0000_0c5a);
    start(MODE_RX4, 3'h5);
    measure(3000);
    chk(16'(n), 16'h00c0);
    rd_chk(BUF_BASE, 8'h0a);
    rd_chk(BUF_BASE + 12'h001, 8'h05);
    rd_chk(BUF_BASE + 12'h002, 8'h0c);
    rd_chk(BUF_BASE + 12'h003, 8'hff);
    // Nibble transmit of the same words, upper half ignored
    bus_wr(BUF_BASE, 8'hfa);
    peer_u.load('0);
    start(MODE_TX4, 3'h5);
    measure(3000);
    chk(16'(n), 16'h00c0);
    chk(peer_u.rx_bits[15:0], 16'h0c5a);
    // Every wait code in byte receive
    for (w = 0; w < 4; w++) begin
      bus_wr(CTRL_TWO, {3'h0, 2'(w), 3'h1});
      peer_u.load(64'h0000_0000_0000_96e1);
      start(MODE_RX8, 3'h5);
      measure(3000);
      chk(16'(n), 16'((32 + ((1 << w) - 1) * 16) * 8));
      rd_chk(BUF_BASE + 12'h001, 8'h96);
    end
    rd_chk(BUF_BASE, 8'he1);
    // Both directions on the external clock
    bus_wr(CTRL_TWO, 8'h01);
    peer_u.load(64'h0000_0000_0000_3c7b);
    start(MODE_TRX8, CLK_EXT);
    #1 chk(sck_oe_n, 1'b1);
    fork
      peer_u.run_clock(16, 213);
      measure(3000);
    join
    chk(peer_u.rx_bits[15:0], 16'h96e1);
    rd_chk(BUF_BASE, 8'h7b);
    rd_chk(BUF_BASE + 12'h001, 8'h3c);
    chk(irq, 1'b1);
    // Low-frequency tap, by option and by slow mode
    bus_wr(CTRL_TWO, 8'h00);
    for (k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      tap <= ~k[0];
      slow <= k[0];
      peer_u.load('0);
      start(MODE_TX8, CLK_SLOW);
      measure(3000);
      chk(16'(n >= 1000 && n <= 1050), 16'h0001);
      chk(peer_u.rx_bits[7:0], 8'h7b);
    end
    @(posedge sys_clk);
    slow <= 1'b0;
    // Stop bit cleared mid-word: word finishes, no completion
    bus_wr(CTRL_TWO, 8'h01);
    bus_wr(IRQ_CLR, 8'h03);
    start(MODE_TX8, 3'h5);
    fork
      measure(3000);
      begin
        repeat (40) @(posedge sys_clk);
        bus_wr(CTRL_ONE, {2'b00, MODE_TX8, 3'h5});
      end
    join
    chk(16'(n), 16'h0080);
    chk(irq, 1'b0);
    // Abort mid-run, then restart without clearing the abort bit
    bus_wr(CTRL_TWO, 8'h07);
    start(MODE_TX8, 3'h5);
    repeat (100) @(posedge sys_clk);
    bus_wr(IRQ_CLR, 8'h03);
    bus_wr(CTRL_ONE, {2'b01, MODE_TX8, 3'h5});
    repeat (3) @(posedge sys_clk);
    #1 chk(active, 1'b0);
    rd_chk(IRQ_STAT, 8'h02);
    bus_wr(CTRL_ONE, {2'b10, MODE_TX8, 3'h5});
    measure(3000);
    chk(16'(n), 16'h0400);
    // Reserved modes and reserved clock never start
    for (k = 0; k < 4; k++) begin
      start(k < 3 ? rsvd[k] : MODE_TX8, k < 3 ? 3'h5 : CLK_RSVD);
      measure(200);
      chk(16'(n), 16'h0000);
    end
    chk(sck_oe_n, 1'b1);
    // Reset in mid-transfer returns every output to idle
    start(MODE_TX8, 3'h5);
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    #1 chk({sdo, sck_out, sck_oe_n, irq, active}, 16'h0018);
    rd_chk(IRQ_EN, 8'h00);
    finish_test;
  end
endmodule
`default_nettype wire
